// ---- at_board_system_decode_bench.sv ----
// Self-checking bench for the system decode block
`timescale 1ns/1ns
`include "sysdec_params.svh"
module at_board_system_decode_bench;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        mem_req = 1'b0;
   logic [23:0] mem_addr = 24'h00_0000;
   logic        io_wr = 1'b0;
   logic        io_rd = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00;
   logic        sh_a = 1'b0;
   logic        sh_s = 1'b0;
   logic        sh_b = 1'b0;
   logic [7:0]  bank_sizes = 8'h00;
   logic [2:0]  dma_chan = 3'h0;
   logic        fpu_busy_set = 1'b0;
   logic [15:0] want_irq = 16'h0000;
   logic        want_par = 1'b0;
   logic        want_chk = 1'b0;
   logic [15:0] irq_in;
   logic        parity_err;
   logic        chan_check;
   logic [7:0]  io_rdata;
   logic        io_on_board;
   logic        io_to_channel;
   logic [2:0]  mem_target;
   logic [1:0]  interleave;
   logic        page_mode;
   logic        speaker;
   logic        refresh_req;
   logic        nmi;
   logic        int_req;
   logic [4:0]  int_level;
   logic [7:0]  dma_page;
   logic        dma_wide;
   logic        dma_allowed;
   logic        fpu_busy;
   logic        fpu_reset;
   int          err_count = 0;
   int          tests_run = 0;
   // Indexed by DMA channel; channel 4 slot holds the refresh page
   logic [15:0] pg_port [8] = '{`PORT_PAGE_CH0, `PORT_PAGE_CH1, `PORT_PAGE_CH2,
      `PORT_PAGE_CH3, `PORT_PAGE_REFRESH, `PORT_PAGE_CH5, `PORT_PAGE_CH6, `PORT_PAGE_CH7};
   logic [23:0] m_addr [6] = '{24'h09_FFFF, 24'h0A_0000, 24'h0C_0000, 24'h0D_FFFF,
      24'h0E_0000, 24'h0F_FFFF};
   logic [2:0]  m_off [6] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5};
   int          m_reg [6] = '{0, 0, 1, 1, 2, 3};
   logic [7:0]  bk [4] = '{8'h02, 8'h09, 8'h0A, 8'hAA};
   logic [1:0]  bk_exp [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
   logic [15:0] iq [6] = '{16'h0108, 16'h010A, 16'h8080, 16'h0200, 16'h0004, 16'h0000};
   logic [4:0]  iq_exp [6] = '{5'd8, 5'd1, 5'd15, 5'd9, 5'd31, 5'd31};

   always #25 clk_sys = ~clk_sys;

   exp_channel_model partner (.clk_sys(clk_sys), .want_irq(want_irq),
      .want_parity(want_par), .want_check(want_chk), .irq_in(irq_in),
      .parity_err(parity_err), .chan_check(chan_check));

   system_decode uut (.clk_sys(clk_sys), .reset_n(reset_n), .mem_req(mem_req),
      .mem_addr(mem_addr), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_on_board(io_on_board),
      .io_to_channel(io_to_channel), .shadow_adaptor(sh_a), .shadow_system(sh_s),
      .shadow_bios(sh_b), .bank_sizes(bank_sizes), .mem_target(mem_target),
      .interleave(interleave), .page_mode(page_mode), .speaker(speaker),
      .refresh_req(refresh_req), .irq_in(irq_in), .parity_err(parity_err),
      .chan_check(chan_check), .nmi(nmi), .int_req(int_req), .int_level(int_level),
      .dma_chan(dma_chan), .dma_page(dma_page), .dma_wide(dma_wide),
      .dma_allowed(dma_allowed), .fpu_busy_set(fpu_busy_set), .fpu_busy(fpu_busy),
      .fpu_reset(fpu_reset));

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clk_sys);
      io_wr <= 1'b0;
      #1;
   endtask

   task automatic io_read(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      io_rd <= 1'b1;
      io_addr <= a;
      @(posedge clk_sys);
      io_rd <= 1'b0;
      #1;
      d = io_rdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Counts speaker transitions over a fixed window
   task automatic count_changes(input int cycles, output int c);
      logic last;
      c = 0;
      last = speaker;
      repeat (cycles) begin
         settle(1);
         if (speaker !== last) c++;
         last = speaker;
      end
   endtask

   // Bounded wait for the next refresh pulse; n is cycles waited
   task automatic wait_refresh(output int n);
      n = 0;
      do begin
         settle(1);
         n++;
      end while (refresh_req !== 1'b1 && n < 12000);
      if (n >= 12000) begin
         err_count++;
         finish_test();
      end
   endtask

   initial begin
      logic [7:0] rd;
      int n;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      settle(1);
      chk({7'h0, page_mode}, 8'h01);
      chk({3'h0, int_level}, 8'h1F);
      io_read(`PORT_PAGE_CH5, rd);
      chk(rd, `PAGE_RESET);
      for (int i = 0; i < 8; i++) io_write(pg_port[i], 8'hA0 + 8'(i));
      io_write(16'h0043, 8'h36);
      for (int i = 0; i < 8; i++) begin
         io_read(pg_port[i], rd);
         chk(rd, 8'hA0 + 8'(i));
         chk({6'h0, io_on_board, io_to_channel}, 8'h02);
      end
      io_read(16'h00FF, rd);
      chk({6'h0, io_on_board, io_to_channel}, 8'h02);
      foreach (pg_port[i]) begin
         io_read(16'h0100 + pg_port[i], rd);
         chk(rd, 8'h00);
         chk({6'h0, io_on_board, io_to_channel}, 8'h01);
      end
      io_read(16'h03FF, rd);
      chk({6'h0, io_on_board, io_to_channel}, 8'h01);
      for (int k = 0; k < 4; k++) begin
         sh_a <= (k == 1);
         sh_b <= (k == 3);
         sh_s <= (k == 2);
         for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            mem_req <= 1'b1;
            mem_addr <= m_addr[i];
            @(posedge clk_sys);
            mem_req <= 1'b0;
            #1;
            chk({5'h0, mem_target}, {5'h0, (k != 0 && m_reg[i] == k) ? 3'h1 : m_off[i]});
         end
      end
      for (int i = 0; i < 4; i++) begin
         bank_sizes <= bk[i];
         settle(2);
         chk({6'h0, interleave}, {6'h0, bk_exp[i]});
         chk({7'h0, page_mode}, 8'h01);
      end
      for (int i = 0; i < 6; i++) begin
         want_irq <= iq[i];
         settle(3);
         chk({3'h0, int_level}, {3'h0, iq_exp[i]});
         chk({7'h0, int_req}, {7'h0, iq_exp[i] != 5'd31});
      end
      want_irq <= 16'h0102;
      want_par <= 1'b1;
      settle(3);
      chk({2'h0, nmi, int_level}, 8'h30);
      want_par <= 1'b0;
      want_chk <= 1'b1;
      settle(3);
      chk({7'h0, nmi}, 8'h01);
      want_chk <= 1'b0;
      settle(3);
      chk({2'h0, nmi, int_level}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         dma_chan <= 3'(i);
         settle(2);
         chk(dma_page, 8'hA0 + 8'(i));
         chk({7'h0, dma_allowed}, {7'h0, i != `DMA_CASCADE_CH});
         if (i != 4) chk({7'h0, dma_wide}, {7'h0, i > 4});
      end
      @(posedge clk_sys);
      fpu_busy_set <= 1'b1;
      @(posedge clk_sys);
      fpu_busy_set <= 1'b0;
      settle(1);
      chk({6'h0, fpu_busy, fpu_reset}, 8'h02);
      io_write(`PORT_FPU_CLR_BUSY, 8'h00);
      chk({6'h0, fpu_busy, fpu_reset}, 8'h00);
      io_write(`PORT_FPU_RESET, 8'h00);
      chk({7'h0, fpu_reset}, 8'h01);
      settle(1);
      chk({7'h0, fpu_reset}, 8'h00);
      io_write(`PORT_TIMER_BASE + 16'h0002, 8'h01);
      io_write(`PORT_SYS_CTRL, 8'h03);
      io_read(`PORT_SYS_CTRL, rd);
      chk(rd, 8'h03);
      count_changes(6000, n);
      chk(8'(n >= 2), 8'h01);
      io_write(`PORT_SYS_CTRL, 8'h02);
      settle(4);
      count_changes(6000, n);
      chk(8'(n), 8'h00);
      // Counter 1 loaded with 256, so refresh comes every 256 ticks of TIMER_CLK_DIV clocks each
      io_write(`PORT_TIMER_BASE + 16'h0001, 8'h01);
      wait_refresh(n);
      settle(1);
      chk({7'h0, refresh_req}, 8'h00);
      wait_refresh(n);
      n = n + 1;
      chk(8'(n >= 256 * `TIMER_CLK_DIV - 17 && n <= 256 * `TIMER_CLK_DIV + 17), 8'h01);
      finish_test();
   end
endmodule

// ---- exp_channel_model.sv ----
// Expansion-channel card stand-in that drives interrupt and check lines
`timescale 1ns/1ns
module exp_channel_model (
   // Clocking
   input  wire logic        clk_sys,
   // Commands from the bench
   input  wire logic [15:0] want_irq,
   input  wire logic        want_parity,
   input  wire logic        want_check,
   // Lines toward the board
   output logic [15:0]      irq_in,
   output logic             parity_err,
   output logic             chan_check
);
   // Cards move their lines just after an edge, never at the sampling instant
   always_ff @(posedge clk_sys) begin
      irq_in <= want_irq;
      parity_err <= want_parity;
      chan_check <= want_check;
   end
endmodule

// ---- irq_priority.sv ----
// Fixed-priority resolver for the sixteen cascaded interrupt levels plus NMI
`timescale 1ns/1ns
module irq_priority (
   // Requests, level 2 of the primary is skipped by the level pick but still sets any_req
   input  wire logic [15:0] irq,
   input  wire logic        nmi_req,
   // Result
   output logic             any_req,
   output logic [4:0]       level
);
   // Order: NMI, 0, 1, 8..15 in the slot of 2, then 3..7
   function automatic logic [4:0] pick(input logic nmi, input logic [15:0] r);
      logic [4:0] res;
      res = 5'h1F;
      if (nmi) res = 5'h10;
      else if (r[0]) res = 5'h00;
      else if (r[1]) res = 5'h01;
      else begin
         for (int i = 15; i >= 3; i--) begin
            if (r[i] && (i < 8)) res = 5'(i);
         end
         for (int i = 15; i >= 8; i--) begin
            if (r[i]) res = 5'(i);
         end
      end
      return res;
   endfunction

   always_comb begin
      level   = pick(nmi_req, irq);
      any_req = nmi_req || (|irq);
   end
endmodule

// ---- sysdec_params.svh ----
// Address map, port offsets and timing constants for the system decode block
`ifndef SYSDEC_PARAMS_SVH
`define SYSDEC_PARAMS_SVH
`define DISPLAY_BASE      20'h0_A000
`define ADAPTOR_ROM_BASE  20'h0_C000
`define SYSTEM_ROM_BASE   20'h0_E000
`define BIOS_ROM_BASE     20'h0_F000
`define ONE_MEG           20'h1_0000
`define IO_BOARD_LAST     16'h0_0FF
`define IO_CHANNEL_LAST   16'h0_3FF
`define PORT_TIMER_BASE   16'h0_040
`define PORT_SYS_CTRL     16'h0_061
`define PORT_PAGE_CH2     16'h0_081
`define PORT_PAGE_CH3     16'h0_082
`define PORT_PAGE_CH1     16'h0_083
`define PORT_PAGE_CH0     16'h0_087
`define PORT_PAGE_CH6     16'h0_089
`define PORT_PAGE_CH7     16'h0_08A
`define PORT_PAGE_CH5     16'h0_08B
`define PORT_PAGE_REFRESH 16'h0_08F
`define PORT_FPU_CLR_BUSY 16'h0_0F0
`define PORT_FPU_RESET    16'h0_0F1
`define SYS_CTRL_RESET    8'h00
`define PAGE_RESET        8'h00
`define TIMER_CLK_DIV     17
`define REFRESH_PERIOD_NS 15000
`define CLK_PERIOD_NS     50
`define CASCADE_LEVEL     2
`define DMA_CASCADE_CH    4
`endif

// ---- sysdec_pkg.sv ----
// Types shared by the system decode block
package sysdec_pkg;
   typedef enum logic [2:0] {
      MEM_NONE, MEM_DRAM, MEM_CHANNEL, MEM_ADAPTOR_ROM, MEM_SYSTEM_ROM, MEM_BIOS_ROM
   } mem_target_t;
   typedef enum logic [1:0] {
      ILV_NONE, ILV_TWO, ILV_FOUR
   } interleave_t;
   typedef enum logic [1:0] {
      BANK_EMPTY, BANK_256K, BANK_1M
   } bank_size_t;
endpackage

// ---- system_decode.sv ----
// System board decode: memory map, I/O split, page registers, timers, interrupts
`timescale 1ns/1ns
`include "sysdec_params.svh"
module system_decode (
   // Clocking
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Processor memory cycle
   input  wire logic        mem_req,
   input  wire logic [23:0] mem_addr,
   // Processor I/O cycle
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [15:0] io_addr,
   input  wire logic [7:0]  io_wdata,
   output logic [7:0]       io_rdata,
   output logic             io_on_board,
   output logic             io_to_channel,
   // Shadow and bank configuration
   input  wire logic        shadow_adaptor,
   input  wire logic        shadow_system,
   input  wire logic        shadow_bios,
   input  wire logic [7:0]  bank_sizes,
   // Memory routing
   output logic [2:0]       mem_target,
   output logic [1:0]       interleave,
   output logic             page_mode,
   // Timers
   output logic             speaker,
   output logic             refresh_req,
   // Interrupts
   input  wire logic [15:0] irq_in,
   input  wire logic        parity_err,
   input  wire logic        chan_check,
   output logic             nmi,
   output logic             int_req,
   output logic [4:0]       int_level,
   // DMA
   input  wire logic [2:0]  dma_chan,
   output logic [7:0]       dma_page,
   output logic             dma_wide,
   output logic             dma_allowed,
   // Coprocessor
   input  wire logic        fpu_busy_set,
   output logic             fpu_busy,
   output logic             fpu_reset
);
   localparam int TICK_DIV = `TIMER_CLK_DIV;
   localparam int REFRESH_TICKS = `REFRESH_PERIOD_NS * 119 / 100000;

   logic [7:0]  sys_ctrl;
   logic [7:0]  page [0:8];
   logic [4:0]  tick_cnt;
   logic        tick;
   logic [2:0]  next_target;
   logic [1:0]  next_ilv;
   logic        next_on_board;
   logic        next_to_channel;
   logic [7:0]  next_rdata;
   logic        next_busy;
   logic        t0_pulse;
   logic        t1_pulse;
   logic        t2_wave;
   logic [15:0] irq_eff;
   logic        next_int_req;
   logic [4:0]  next_level;
   logic [15:0] timer_reload;
   logic [2:0]  timer_load;

   // Maps a page-register port to its slot, slot 8 being unused ports
   function automatic logic [3:0] page_slot(input logic [15:0] a);
      case (a)
         `PORT_PAGE_CH0:     page_slot = 4'h0;
         `PORT_PAGE_CH1:     page_slot = 4'h1;
         `PORT_PAGE_CH2:     page_slot = 4'h2;
         `PORT_PAGE_CH3:     page_slot = 4'h3;
         `PORT_PAGE_REFRESH: page_slot = 4'h4;
         `PORT_PAGE_CH5:     page_slot = 4'h5;
         `PORT_PAGE_CH6:     page_slot = 4'h6;
         `PORT_PAGE_CH7:     page_slot = 4'h7;
         default:            page_slot = 4'h8;
      endcase
   endfunction

   function automatic sysdec_pkg::bank_size_t bank(input logic [7:0] s, input int i);
      return sysdec_pkg::bank_size_t'(s[2*i +: 2]);
   endfunction

   // Memory target
   always_comb begin
      logic [19:0] kb4;
      kb4 = mem_addr[23:4];
      next_target = 3'(sysdec_pkg::MEM_DRAM);
      if (!mem_req) next_target = 3'(sysdec_pkg::MEM_NONE);
      else if (kb4 >= `ONE_MEG) next_target = 3'(sysdec_pkg::MEM_DRAM);
      else if (kb4 >= `BIOS_ROM_BASE)
         next_target = shadow_bios ? 3'(sysdec_pkg::MEM_DRAM) : 3'(sysdec_pkg::MEM_BIOS_ROM);
      else if (kb4 >= `SYSTEM_ROM_BASE)
         next_target = shadow_system ? 3'(sysdec_pkg::MEM_DRAM)
                                     : 3'(sysdec_pkg::MEM_SYSTEM_ROM);
      else if (kb4 >= `ADAPTOR_ROM_BASE)
         next_target = shadow_adaptor ? 3'(sysdec_pkg::MEM_DRAM)
                                      : 3'(sysdec_pkg::MEM_ADAPTOR_ROM);
      else if (kb4 >= `DISPLAY_BASE) next_target = 3'(sysdec_pkg::MEM_CHANNEL);
   end

   // Interleave from the installed bank mix, only for matching sets
   always_comb begin
      sysdec_pkg::bank_size_t b0, b1, b2, b3;
      b0 = bank(bank_sizes, 0);
      b1 = bank(bank_sizes, 1);
      b2 = bank(bank_sizes, 2);
      b3 = bank(bank_sizes, 3);
      next_ilv = 2'(sysdec_pkg::ILV_NONE);
      if (b0 == sysdec_pkg::BANK_1M && b1 == b0 && b2 == b0 && b3 == b0)
         next_ilv = 2'(sysdec_pkg::ILV_FOUR);
      else if ((b0 != sysdec_pkg::BANK_EMPTY && b0 == b1) ||
               (b1 != sysdec_pkg::BANK_EMPTY && b1 == b2) ||
               (b2 != sysdec_pkg::BANK_EMPTY && b2 == b3))
         next_ilv = 2'(sysdec_pkg::ILV_TWO);
   end

   // I/O split and read-back
   always_comb begin
      next_on_board   = (io_rd || io_wr) && (io_addr <= `IO_BOARD_LAST);
      next_to_channel = (io_rd || io_wr) && (io_addr > `IO_BOARD_LAST)
                        && (io_addr <= `IO_CHANNEL_LAST);
      next_rdata = 8'h00;
      if (io_rd && page_slot(io_addr) != 4'h8) next_rdata = page[page_slot(io_addr)];
      else if (io_rd && io_addr == `PORT_SYS_CTRL) next_rdata = sys_ctrl;
      // Hardware set wins over a clearing write in the same cycle
      next_busy = fpu_busy;
      if (io_wr && io_addr == `PORT_FPU_CLR_BUSY) next_busy = 1'b0;
      if (fpu_busy_set) next_busy = 1'b1;
   end

   // Four timer ports: counters 0..2 at base+0..2, writes to base+3 are ignored
   always_comb begin
      timer_reload = {io_wdata, 8'h00};
      timer_load   = 3'b000;
      if (io_wr && io_addr[15:2] == `PORT_TIMER_BASE >> 2 && io_addr[1:0] != 2'b11)
         timer_load[io_addr[1:0]] = 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sys_ctrl <= `SYS_CTRL_RESET;
         for (int i = 0; i < 9; i++) page[i] <= `PAGE_RESET;
         tick_cnt <= 5'h00;
         tick     <= 1'b0;
      end else begin
         if (io_wr && io_addr == `PORT_SYS_CTRL) sys_ctrl <= io_wdata;
         if (io_wr) page[page_slot(io_addr)] <= io_wdata;
         // Shared prescaler: 20 MHz / 17 is about 1.18 MHz
         tick     <= (tick_cnt == 5'(TICK_DIV - 1));
         tick_cnt <= (tick_cnt == 5'(TICK_DIV - 1)) ? 5'h00 : tick_cnt + 5'h01;
      end
   end

   timer_channel u_t0 (.clk_sys(clk_sys), .reset_n(reset_n), .tick(tick), .gate(1'b1),
      .load(timer_load[0]), .reload(timer_reload), .wave(), .period_pulse(t0_pulse));
   timer_channel u_t1 (.clk_sys(clk_sys), .reset_n(reset_n), .tick(tick), .gate(1'b1),
      .load(timer_load[1]), .reload(timer_reload), .wave(), .period_pulse(t1_pulse));
   // Only the speaker channel has a software gate
   timer_channel u_t2 (.clk_sys(clk_sys), .reset_n(reset_n), .tick(tick),
      .gate(sys_ctrl[0]), .load(timer_load[2]), .reload(timer_reload),
      .wave(t2_wave), .period_pulse());

   // Level 0 from timer, level 2 replaced by the cascade of 8..15
   always_comb begin
      irq_eff    = irq_in;
      // Rising edge of the tick output; the idle-high wave would hold level 0 forever
      irq_eff[0] = t0_pulse;
      irq_eff[`CASCADE_LEVEL] = 1'b0;
   end

   irq_priority u_prio (.irq(irq_eff), .nmi_req(parity_err || chan_check),
      .any_req(next_int_req), .level(next_level));

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         mem_target <= 3'(sysdec_pkg::MEM_NONE);
         interleave <= 2'(sysdec_pkg::ILV_NONE);
         page_mode <= 1'b1;
         io_rdata <= 8'h00;
         io_on_board <= 1'b0;
         io_to_channel <= 1'b0;
         speaker <= 1'b0;
         refresh_req <= 1'b0;
         nmi <= 1'b0;
         int_req <= 1'b0;
         int_level <= 5'h1F;
         dma_page <= 8'h00;
         dma_wide <= 1'b0;
         dma_allowed <= 1'b0;
         fpu_busy <= 1'b0;
         fpu_reset <= 1'b0;
      end else begin
         mem_target <= next_target;
         interleave <= next_ilv;
         page_mode <= 1'b1;
         io_rdata <= next_rdata;
         io_on_board <= next_on_board;
         io_to_channel <= next_to_channel;
         speaker <= t2_wave && sys_ctrl[1];
         refresh_req <= t1_pulse;
         nmi <= parity_err || chan_check;
         int_req <= next_int_req;
         int_level <= next_level;
         dma_page <= (dma_chan == 3'(`DMA_CASCADE_CH)) ? page[4] : page[dma_chan];
         dma_wide <= dma_chan[2];
         dma_allowed <= (dma_chan != 3'(`DMA_CASCADE_CH));
         fpu_busy <= next_busy;
         fpu_reset <= io_wr && io_addr == `PORT_FPU_RESET;
      end
   end

   // Page mode never drops
   page_mode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ##1 page_mode) else $error("page mode dropped");
   io_split_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(io_on_board && io_to_channel)) else $error("I/O decoded to both sides");
   chan_fwd_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (io_wr || io_rd) && io_addr >= 16'h0_100 && io_addr <= 16'h0_3FF |=> io_to_channel)
      else $error("channel I/O not forwarded");
   bios_rom_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      mem_req && mem_addr[23:16] == 8'h0F && !shadow_bios |=> mem_target == 3'(5))
      else $error("BIOS region misrouted");
   display_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      mem_req && mem_addr[23:17] == 7'h05 |=> mem_target == 3'(2))
      else $error("display buffer misrouted");
   nmi_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      chan_check |=> nmi) else $error("NMI not raised");
   cascade_ch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      dma_chan == 3'h4 |=> !dma_allowed) else $error("cascade channel usable");
   fpu_clr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      io_wr && io_addr == 16'h0_0F0 && !fpu_busy_set |=> !fpu_busy)
      else $error("coprocessor busy not cleared");
   sequence page_wr_s;
      io_wr && io_addr == 16'h0_087 ##1 1'b1;
   endsequence
   page_rb_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      page_wr_s |-> page[0] == $past(io_wdata, 1)) else $error("page register lost");
   ilv_four_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      bank_sizes == 8'hAA |=> interleave == 2'(2)) else $error("four-way missing");
   refresh_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      t1_pulse |=> refresh_req) else $error("refresh not requested");
endmodule

// ---- timer_channel.sv ----
// One down-counting timer channel with gate, square-wave output and reload pulse
`timescale 1ns/1ns
module timer_channel (
   // Clocking
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Control
   input  wire logic        tick,
   input  wire logic        gate,
   input  wire logic        load,
   input  wire logic [15:0] reload,
   // Output
   output logic             wave,
   output logic             period_pulse
);
   logic [15:0] count;
   logic [15:0] divisor;
   logic [15:0] next_count;
   logic [15:0] next_divisor;
   logic        next_wave;
   logic        next_pulse;

   always_comb begin
      next_count   = count;
      next_divisor = divisor;
      next_wave    = wave;
      next_pulse   = 1'b0;
      if (load) begin
         next_divisor = reload;
         next_count   = reload;
         next_wave    = 1'b1;
      end else if (tick && gate && divisor != 16'h0000) begin
         // An unprogrammed channel stays idle instead of pulsing on every tick
         if (count <= 16'h0001) begin
            next_count = divisor;
            next_pulse = 1'b1;
            next_wave  = 1'b1;
         end else begin
            next_count = count - 16'h0001;
            // Low for the second half of each period
            if (count == {1'b0, divisor[15:1]}) begin
               next_wave = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         count        <= 16'h0000;
         divisor      <= 16'h0000;
         wave         <= 1'b1;
         period_pulse <= 1'b0;
      end else begin
         count        <= next_count;
         divisor      <= next_divisor;
         wave         <= next_wave;
         period_pulse <= next_pulse;
      end
   end
endmodule
